// ===== inc/dsk_port_pkg.sv
// constants and types shared by the diskette host flag port
`default_nettype none
package dsk_port_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned STATUS_MS     = 250;
  localparam int unsigned STATUS_CYCLES = (CLK_HZ / 1000) * STATUS_MS;
  localparam logic [7:0]  WORDS_12      = 8'h40;
  localparam logic [7:0]  BYTES_8       = 8'h80;
  localparam int unsigned MODE_BIT      = 6;
  localparam int unsigned DRIVE_BIT     = 4;
  localparam int unsigned FUNC_LSB      = 1;
  localparam logic [2:0]  FN_FILL       = 3'h0;
  localparam logic [2:0]  FN_EMPTY      = 3'h1;
  localparam logic [2:0]  FN_STATUS     = 3'h5;
  localparam logic [2:0]  FN_ERRREG     = 3'h7;
  localparam int unsigned ST_PARITY_BIT = 1;
  localparam int unsigned ST_READY_BIT  = 7;
  localparam logic [7:0]  ST_MASK       = 8'hff;
  localparam logic [11:0] ERR_NONE      = 12'h000;
  localparam logic [11:0] ERR_INIT_D0   = 12'o0010;
  localparam logic [11:0] ERR_INIT_D1   = 12'o0020;
  localparam logic [11:0] ERR_INIT_OUT  = 12'o0030;
  localparam logic [11:0] ERR_TRK_HIGH  = 12'o0040;
  localparam logic [11:0] ERR_HOME_EARLY = 12'o0050;
  localparam logic [11:0] ERR_DIAG      = 12'o0060;
  localparam logic [11:0] ERR_NO_SECTOR = 12'o0070;
  localparam logic [11:0] ERR_NO_CLOCK  = 12'o0110;
  localparam logic [11:0] ERR_NO_PREAMB = 12'o0120;
  localparam logic [11:0] ERR_NO_IOMARK = 12'o0130;
  localparam logic [11:0] ERR_HDR_CRC   = 12'o0140;
  localparam logic [11:0] ERR_TRK_MISMATCH = 12'o0150;
  localparam logic [11:0] ERR_IDMARK    = 12'o0160;
  localparam logic [11:0] ERR_DATA_MARK = 12'o0170;
  localparam logic [11:0] ERR_DATA_CRC  = 12'o0200;
  localparam logic [11:0] ERR_PARITY    = 12'o0210;
  localparam logic [5:0]  MAX_HEADERS   = 6'd52;
  localparam logic [4:0]  SECTOR_MAX    = 5'd26;
  localparam logic [6:0]  TRACK_MAX     = 7'd76;
  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_XFER   = 2'b01,
    PS_ENGINE = 2'b10,
    PS_WAIT   = 2'b11
  } phase_t;
endpackage
`default_nettype wire

// ===== rtl/dsk_host_port.sv
// host-facing command, flag and transfer port of the diskette controller
//
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
module dsk_host_port #(
  parameter int unsigned STATUS_WAIT = dsk_port_pkg::STATUS_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // host instructions
  input  wire logic        load_command_word_in,
  input  wire logic        transfer_data_word_in,
  input  wire logic        skip_on_xfer_request_in,
  input  wire logic        skip_on_done_flag_in,
  input  wire logic        skip_on_error_flag_in,
  input  wire logic        initialize_in,
  input  wire logic [11:0] host_data_in,
  input  wire logic        host_parity_err_in,
  output logic      [11:0] host_data_out,
  output logic             skip_out,
  // sector buffer side
  output logic      [6:0]  buf_index_out,
  output logic             buf_write_out,
  output logic      [11:0] buf_wdata_out,
  input  wire logic [11:0] buf_rdata_in,
  // engine side
  output logic             engine_start_out,
  output logic      [2:0]  engine_func_out,
  output logic             engine_drive_out,
  input  wire logic        engine_done_in,
  input  wire logic [11:0] engine_err_code_in,
  input  wire logic        drive_ready_in,
  input  wire logic        engine_crc_err_in,
  // flags
  output logic             transfer_request_flag_out,
  output logic             done_flag_out,
  output logic             error_flag_out
);
  typedef struct packed {
    dsk_port_pkg::phase_t phase;
    logic [11:0] iface;
    logic [11:0] command;
    logic [11:0] err_code;
    logic [7:0]  count;
    logic [7:0]  total;
    logic        xfer_flag;
    logic        done_flag;
    logic        err_flag;
    logic        busy;
    logic        parity_seen;
    logic        ready_valid;
    logic        start;
    logic        bwrite;
    logic [11:0] bwdata;
    logic        skip;
    logic [31:0] timer;
    logic        init_run;
    logic        eng_done;
    logic [11:0] eng_code;
    logic        eng_crc;
  } state_t;

  state_t cur;
  state_t nxt;

  function automatic logic [11:0] status_word(input logic [11:0] cmd, input logic par,
                                              input logic crc, input logic rdy);
    logic [11:0] w;
    w = {cmd[11:8], 8'h00};
    w[dsk_port_pkg::ST_PARITY_BIT] = par;
    w[0] = crc;
    w[dsk_port_pkg::ST_READY_BIT] = rdy;
    return w;
  endfunction

  logic [2:0] func;
  logic       mode8;
  assign func  = host_data_in[dsk_port_pkg::FUNC_LSB +: 3];
  assign mode8 = host_data_in[dsk_port_pkg::MODE_BIT];

  always_comb begin
    nxt        = cur;
    nxt.start  = 1'b0;
    nxt.bwrite = 1'b0;
    nxt.skip   = 1'b0;
    // tests clear their own flag; a set in the same cycle wins below
    if (skip_on_xfer_request_in) begin
      nxt.skip      = cur.xfer_flag;
      nxt.xfer_flag = 1'b0;
    end
    if (skip_on_done_flag_in) begin
      nxt.skip      = cur.done_flag;
      nxt.done_flag = 1'b0;
    end
    if (skip_on_error_flag_in) begin
      nxt.skip     = cur.err_flag;
      nxt.err_flag = 1'b0;
    end
    if (host_parity_err_in && (load_command_word_in || transfer_data_word_in)) begin
      nxt.parity_seen = 1'b1;
    end
    case (cur.phase)
      dsk_port_pkg::PS_IDLE: begin
        if (load_command_word_in) begin
          nxt.command     = host_data_in;
          nxt.busy        = 1'b1;
          nxt.done_flag   = 1'b0;
          nxt.err_flag    = 1'b0;
          nxt.parity_seen = host_parity_err_in;
          nxt.count       = 8'h00;
          nxt.init_run    = 1'b0;
          nxt.eng_done    = 1'b0;
          // selector adds octal 100 for byte mode
          nxt.total = mode8 ? dsk_port_pkg::BYTES_8 : dsk_port_pkg::WORDS_12;
          if (func == dsk_port_pkg::FN_FILL || func == dsk_port_pkg::FN_EMPTY) begin
            // first item is fetched in the wait phase, once the index is back at zero
            nxt.phase     = dsk_port_pkg::PS_WAIT;
            nxt.xfer_flag = 1'b0;
            // buffer functions never look at the drive bit
          end else begin
            nxt.phase = dsk_port_pkg::PS_ENGINE;
            nxt.start = 1'b1;
            nxt.timer = '0;
            if (func == dsk_port_pkg::FN_STATUS) begin
              nxt.ready_valid = 1'b0;
            end
          end
        end
      end
      dsk_port_pkg::PS_XFER: begin
        if (transfer_data_word_in) begin
          if (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_FILL) begin
            nxt.bwrite = 1'b1;
            nxt.bwdata = cur.command[dsk_port_pkg::MODE_BIT] ? {4'h0, host_data_in[7:0]}
                                                             : host_data_in;
          end
          nxt.count     = cur.count + 8'h01;
          nxt.xfer_flag = 1'b0;
          if (cur.count + 8'h01 == cur.total) begin
            nxt.phase = dsk_port_pkg::PS_WAIT;
          end else begin
            nxt.phase = dsk_port_pkg::PS_WAIT;
          end
        end
      end
      dsk_port_pkg::PS_WAIT: begin
        if (cur.count == cur.total) begin
          // only parity can fail a buffer function
          nxt.err_code = cur.parity_seen ? dsk_port_pkg::ERR_PARITY : cur.err_code;
          nxt.err_flag = cur.parity_seen;
          nxt.iface    = status_word(cur.command, cur.parity_seen, 1'b0, 1'b0);
          nxt.done_flag = 1'b1;
          nxt.busy     = 1'b0;
          nxt.phase    = dsk_port_pkg::PS_IDLE;
        end else begin
          if (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_EMPTY) begin
            nxt.iface = buf_rdata_in;
          end
          nxt.xfer_flag = 1'b1;
          nxt.phase     = dsk_port_pkg::PS_XFER;
        end
      end
      dsk_port_pkg::PS_ENGINE: begin
        if (cur.timer != 32'hffff_ffff) begin
          nxt.timer = cur.timer + 32'd1;
        end
        // the engine pulses done once; hold it and its code until the status wait is over
        if (engine_done_in) begin
          nxt.eng_done = 1'b1;
          nxt.eng_code = engine_err_code_in;
          nxt.eng_crc  = engine_crc_err_in;
        end
        if ((engine_done_in || cur.eng_done) && (cur.command[dsk_port_pkg::FUNC_LSB +: 3] !=
            dsk_port_pkg::FN_STATUS || cur.timer >= STATUS_WAIT - 1)) begin
          nxt.phase     = dsk_port_pkg::PS_IDLE;
          nxt.busy      = 1'b0;
          nxt.done_flag = 1'b1;
          // a parity hit on this command replaces the engine's code
          nxt.err_code  = cur.parity_seen ? dsk_port_pkg::ERR_PARITY
                                          : nxt.eng_code;
          nxt.err_flag  = cur.parity_seen || nxt.eng_code != dsk_port_pkg::ERR_NONE;
          if (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_STATUS) begin
            nxt.ready_valid = 1'b1;
          end
          if (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_ERRREG &&
              !cur.init_run) begin
            nxt.iface = cur.parity_seen ? dsk_port_pkg::ERR_PARITY : nxt.eng_code;
          end else begin
            // old command bits stay above the status byte; ready only for status or init
            nxt.iface = status_word(cur.command, cur.parity_seen, nxt.eng_crc,
              drive_ready_in &&
              (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_STATUS ||
               (cur.init_run && !cur.command[dsk_port_pkg::DRIVE_BIT])));
          end
        end
      end
      default: nxt.phase = dsk_port_pkg::PS_IDLE;
    endcase
    // initialize aborts anything and runs the engine init
    if (initialize_in) begin
      nxt.phase     = dsk_port_pkg::PS_ENGINE;
      nxt.command   = 12'h00e;
      nxt.busy      = 1'b1;
      nxt.done_flag = 1'b0;
      nxt.err_flag  = 1'b0;
      nxt.xfer_flag = 1'b0;
      nxt.parity_seen = 1'b0;
      nxt.init_run  = 1'b1;
      nxt.eng_done  = 1'b0;
      nxt.start     = 1'b1;
      nxt.timer     = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur       <= '0;
      cur.phase <= dsk_port_pkg::PS_IDLE;
    end else begin
      cur <= nxt;
    end
  end

  assign host_data_out             = cur.iface;
  assign skip_out                  = cur.skip;
  // the count moves on with the write pulse, so the write goes to the item before it
  assign buf_index_out             = cur.count[6:0] - {6'h00, cur.bwrite};
  assign buf_write_out             = cur.bwrite;
  assign buf_wdata_out             = cur.bwdata;
  assign engine_start_out          = cur.start;
  assign engine_func_out           = cur.command[dsk_port_pkg::FUNC_LSB +: 3];
  assign engine_drive_out          = cur.command[dsk_port_pkg::DRIVE_BIT];
  assign transfer_request_flag_out = cur.xfer_flag;
  assign done_flag_out             = cur.done_flag;
  assign error_flag_out            = cur.err_flag;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cmd_taken;
    load_command_word_in && cur.phase == dsk_port_pkg::PS_IDLE && !initialize_in;
  endsequence

  AST_DONE_DROPS: assert property (s_cmd_taken |=> !done_flag_out)
    else $error("done stays up after command");
  AST_BUSY_NO_DONE: assert property (cur.busy |-> !done_flag_out)
    else $error("done while busy");
  AST_SKIP_CLEARS_DONE: assert property (skip_on_done_flag_in && !cur.busy
      && !initialize_in |=> !done_flag_out)
    else $error("done not cleared by test");
  AST_SKIP_REPORTS: assert property (skip_on_xfer_request_in && !skip_on_done_flag_in &&
      !skip_on_error_flag_in |=> skip_out == $past(transfer_request_flag_out))
    else $error("skip does not reflect flag");
  AST_COUNT_LIMIT: assert property (cur.count <= cur.total)
    else $error("more items than buffer holds");
  AST_TOTAL_MODE: assert property (s_cmd_taken ##2 (cur.phase == dsk_port_pkg::PS_XFER)
      |-> cur.total == (cur.command[dsk_port_pkg::MODE_BIT] ? 8'h80 : 8'h40))
    else $error("wrong item count for mode");
  AST_BUF_ERR_PARITY: assert property ($rose(done_flag_out) && error_flag_out &&
      cur.command[3:2] == 2'b00 |-> cur.err_code == dsk_port_pkg::ERR_PARITY)
    else $error("buffer function reported non-parity error");
  AST_FLAG_PULSE_WRITE: assert property (buf_write_out |-> $past(transfer_data_word_in))
    else $error("buffer write without transfer");

  sequence s_buf_cmd;
    s_cmd_taken ##0 (func == dsk_port_pkg::FN_FILL || func == dsk_port_pkg::FN_EMPTY);
  endsequence

  sequence s_eng_cmd;
    s_cmd_taken ##0 !(func == dsk_port_pkg::FN_FILL || func == dsk_port_pkg::FN_EMPTY);
  endsequence

  sequence s_xfer_taken;
    transfer_data_word_in && cur.phase == dsk_port_pkg::PS_XFER && !initialize_in;
  endsequence

  sequence s_fill_taken;
    s_xfer_taken ##0 (cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_FILL);
  endsequence

  AST_BUF_GOES_WAIT: assert property (s_buf_cmd
      |=> cur.phase == dsk_port_pkg::PS_WAIT && !transfer_request_flag_out)
    else $error("buffer command did not enter wait");

  AST_COUNT_STARTS_ZERO: assert property (s_buf_cmd |=> cur.count == 8'h00)
    else $error("item count not cleared");

  AST_ENG_START: assert property (s_eng_cmd
      |=> engine_start_out && cur.phase == dsk_port_pkg::PS_ENGINE)
    else $error("engine function not started");

  AST_INIT_START: assert property (initialize_in
      |=> engine_start_out && !done_flag_out && !transfer_request_flag_out)
    else $error("initialize did not restart");

  AST_XFER_DROPS_FLAG: assert property (s_xfer_taken
      |=> !transfer_request_flag_out && cur.phase == dsk_port_pkg::PS_WAIT)
    else $error("request stays after transfer");

  AST_XFER_COUNTS: assert property (s_xfer_taken
      |=> cur.count == $past(cur.count) + 8'h01)
    else $error("item count did not advance");

  AST_FILL_WRITES: assert property (s_fill_taken
      |=> buf_write_out && buf_index_out == $past(cur.count[6:0]))
    else $error("fill item written to wrong place");

  AST_FILL_BYTE: assert property (s_fill_taken ##0 cur.command[dsk_port_pkg::MODE_BIT]
      |=> buf_wdata_out[11:8] == 4'h0)
    else $error("byte mode wrote upper bits");

  AST_EMPTY_NO_WRITE: assert property (
      cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_EMPTY
      |-> !buf_write_out)
    else $error("empty buffer wrote the buffer");

  AST_WAIT_RELOADS: assert property (cur.phase == dsk_port_pkg::PS_WAIT &&
      cur.count != cur.total && !initialize_in
      |=> transfer_request_flag_out && cur.phase == dsk_port_pkg::PS_XFER)
    else $error("next request not raised");

  AST_LAST_ITEM_DONE: assert property (cur.phase == dsk_port_pkg::PS_WAIT &&
      cur.count == cur.total && !initialize_in
      |=> done_flag_out && !transfer_request_flag_out && !cur.busy)
    else $error("done missing after last item");

  AST_IDLE_NO_REQUEST: assert property (cur.phase == dsk_port_pkg::PS_IDLE
      |-> !transfer_request_flag_out)
    else $error("request while idle");

  AST_ENGINE_NO_REQUEST: assert property (cur.phase == dsk_port_pkg::PS_ENGINE
      |-> !transfer_request_flag_out)
    else $error("request during engine function");

  AST_IDLE_NOT_BUSY: assert property (cur.phase == dsk_port_pkg::PS_IDLE
      |-> !cur.busy)
    else $error("busy while idle");

  AST_ACTIVE_BUSY: assert property (cur.phase != dsk_port_pkg::PS_IDLE
      |-> cur.busy)
    else $error("function running without busy");

  AST_CMD_IGNORED_BUSY: assert property (load_command_word_in && cur.busy && !initialize_in
      |=> cur.command == $past(cur.command))
    else $error("command taken while busy");

  AST_BUF_NO_ENGINE: assert property (cur.phase == dsk_port_pkg::PS_XFER ||
      cur.phase == dsk_port_pkg::PS_WAIT |-> !engine_start_out)
    else $error("engine started for buffer function");

  AST_STATUS_MIN_WAIT: assert property (cur.phase == dsk_port_pkg::PS_ENGINE &&
      cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_STATUS &&
      cur.timer < STATUS_WAIT - 1 |=> !done_flag_out)
    else $error("status finished too early");

  AST_ENGINE_DONE_HELD: assert property (engine_done_in &&
      cur.phase == dsk_port_pkg::PS_ENGINE && !initialize_in
      |=> cur.eng_done || cur.phase == dsk_port_pkg::PS_IDLE)
    else $error("engine done lost");

  AST_PARITY_SETS_ERR: assert property ($rose(done_flag_out) && cur.parity_seen
      |-> error_flag_out)
    else $error("parity without error flag");

  AST_ERRREG_PARITY: assert property ($rose(done_flag_out) && cur.parity_seen &&
      cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_ERRREG && !cur.init_run
      |-> host_data_out == dsk_port_pkg::ERR_PARITY)
    else $error("error register hides new parity");

  AST_STATUS_UPPER: assert property ($rose(done_flag_out) &&
      !(cur.command[dsk_port_pkg::FUNC_LSB +: 3] == dsk_port_pkg::FN_ERRREG && !cur.init_run)
      |-> host_data_out[11:8] == cur.command[11:8])
    else $error("status word upper bits wrong");

  AST_READY_ONLY_VALID: assert property ($rose(done_flag_out) && !cur.init_run &&
      cur.command[dsk_port_pkg::FUNC_LSB +: 3] != dsk_port_pkg::FN_STATUS &&
      cur.command[dsk_port_pkg::FUNC_LSB +: 3] != dsk_port_pkg::FN_ERRREG
      |-> !host_data_out[dsk_port_pkg::ST_READY_BIT])
    else $error("drive ready shown when not valid");

  AST_SKIP_ONE_CYCLE: assert property (!skip_on_xfer_request_in && !skip_on_done_flag_in &&
      !skip_on_error_flag_in |=> !skip_out)
    else $error("skip without a test");

  AST_SKIP_DONE_REPORTS: assert property (skip_on_done_flag_in && !skip_on_xfer_request_in &&
      !skip_on_error_flag_in |=> skip_out == $past(done_flag_out))
    else $error("skip does not reflect done");

  AST_SKIP_ERR_REPORTS: assert property (skip_on_error_flag_in && !skip_on_xfer_request_in &&
      !skip_on_done_flag_in |=> skip_out == $past(error_flag_out))
    else $error("skip does not reflect error");

  AST_ERR_TEST_CLEARS: assert property (skip_on_error_flag_in &&
      cur.phase == dsk_port_pkg::PS_IDLE |=> !error_flag_out)
    else $error("error not cleared by test");

  AST_XFER_TEST_CLEARS: assert property (skip_on_xfer_request_in &&
      cur.phase != dsk_port_pkg::PS_WAIT |=> !transfer_request_flag_out)
    else $error("request not cleared by test");
endmodule
`default_nettype wire

// ===== dv/dsk_far_model.sv
// sector buffer and engine stand-in on the far side of the host flag port
`default_nettype none
module dsk_far_model (
  // clock
  input  wire logic        core_clk_in,
  // sector buffer
  input  wire logic [6:0]  buf_index_in,
  input  wire logic        buf_write_in,
  input  wire logic [11:0] buf_wdata_in,
  output logic      [11:0] buf_rdata_out,
  // engine
  input  wire logic        engine_start_in,
  input  wire logic [11:0] code_in,
  output logic             engine_done_out,
  output logic      [11:0] engine_err_code_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] mem [128];
  int          wait_n;
  initial begin
    foreach (mem[i]) mem[i] = 12'h000;
    wait_n = 0;
    engine_done_out = 1'b0;
  end
  assign buf_rdata_out = mem[buf_index_in];
  // code only valid with done; otherwise inverted so a stale read shows up
  assign engine_err_code_out = engine_done_out ? code_in : ~code_in;
  always @(posedge core_clk_in) begin
    if (buf_write_in) mem[buf_index_in] <= buf_wdata_in;
    engine_done_out <= (wait_n == 1);
    if (engine_start_in) wait_n <= 4;
    else if (wait_n != 0) wait_n <= wait_n - 1;
  end
endmodule
`default_nettype wire

// ===== dv/tb_dsk_host_port.sv
// self-checking bench for the diskette host flag port
`default_nettype none
module tb_dsk_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  st = 6'h00;
  logic [11:0] hd = 12'h000;
  logic        par = 1'b0;
  logic        rdy = 1'b1;
  logic        crc = 1'b0;
  logic [11:0] eng_code = 12'h000;
  logic [11:0] hq, bw, br, ec;
  logic [11:0] got [128];
  logic [6:0]  bi;
  logic        skip, bwr, es, ed, edn, trf, dnf, erf;
  logic [2:0]  ef;
  int          fail_count = 0;
  int          checked = 0;
  int          n, cyc;
  // rows: engine code in, same code expected in the low byte
  logic [11:0] rows [16] = '{12'h008, 12'h010, 12'h018, 12'h020, 12'h028, 12'h030,
    12'h038, 12'h048, 12'h050, 12'h058, 12'h060, 12'h068, 12'h070, 12'h078, 12'h080, 12'h088};
  always #50 core_clk = ~core_clk;
  dsk_host_port #(.STATUS_WAIT(10)) uut (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .load_command_word_in(st[0]), .transfer_data_word_in(st[1]),
    .skip_on_xfer_request_in(st[2]), .skip_on_done_flag_in(st[3]),
    .skip_on_error_flag_in(st[4]), .initialize_in(st[5]), .host_data_in(hd),
    .host_parity_err_in(par), .host_data_out(hq), .skip_out(skip), .buf_index_out(bi),
    .buf_write_out(bwr), .buf_wdata_out(bw), .buf_rdata_in(br), .engine_start_out(es),
    .engine_func_out(ef), .engine_drive_out(ed), .engine_done_in(edn),
    .engine_err_code_in(ec), .drive_ready_in(rdy), .engine_crc_err_in(crc),
    .transfer_request_flag_out(trf), .done_flag_out(dnf), .error_flag_out(erf));
  dsk_far_model far (.core_clk_in(core_clk), .buf_index_in(bi), .buf_write_in(bwr),
    .buf_wdata_in(bw), .buf_rdata_out(br), .engine_start_in(es), .code_in(eng_code),
    .engine_done_out(edn), .engine_err_code_out(ec));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp(nm, {11'h000, e}, {11'h000, g});
  endtask
  task automatic cmp_cnt(input string nm, input int e, input int g);
    cmp(nm, 12'(e), 12'(g));
  endtask
  // one strobe cycle; strobes are released at the edge that takes them
  task automatic op(input logic [5:0] s, input logic [11:0] d, input logic p);
    @(posedge core_clk);
    st <= s;
    hd <= d;
    par <= p;
    @(posedge core_clk);
    st <= 6'h00;
    par <= 1'b0;
  endtask
  task automatic skipchk(input logic [5:0] s, input logic e, input string nm);
    op(s, 12'h000, 1'b0);
    #1;
    cmp_bit(nm, e, skip);
  endtask
  // host loop: one item per request seen, until done
  task automatic run(input logic [5:0] s, input logic [11:0] c, input logic p, input logic f);
    n = 0;
    cyc = 0;
    op(s, c, p);
    #1;
    cmp_bit("done low", 1'b0, dnf);
    for (int k = 0; k < 3000 && dnf !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (trf === 1'b1) begin
        op(6'h02, f ? 12'h5a3 ^ 12'(n) : 12'h000, p);
        #1;
        got[n[6:0]] = hq;
        n++;
      end
    end
    if (dnf !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    cmp_bit("flags in reset", 1'b0, trf | dnf | erf | skip);
    cmp("data in reset", 12'h000, hq);
    rst_n <= 1'b1;
    $display("test reset done");
    run(6'h20, 12'h000, 1'b0, 1'b0);
    cmp_bit("ready after init", rdy, hq[dsk_port_pkg::ST_READY_BIT]);
    skipchk(6'h08, 1'b1, "done test");
    skipchk(6'h08, 1'b0, "done cleared");
    for (int m = 0; m < 2; m++) begin
      run(6'h01, m ? 12'h050 : 12'h000, 1'b0, 1'b1);
      cmp_cnt("fill items", m ? 128 : 64, n);
      skipchk(6'h10, 1'b0, "fill error");
      run(6'h01, m ? 12'h042 : 12'h002, 1'b0, 1'b0);
      cmp_cnt("empty items", m ? 128 : 64, n);
      for (int i = 0; i < 64 + 64 * m; i++)
        cmp("empty data", (12'h5a3 ^ 12'(i)) & (m ? 12'h0ff : 12'hfff),
          got[i] & (m ? 12'h0ff : 12'hfff));
      $display("test buffer mode %0d done", m);
    end
    // ordinary cases: every error code through the error register function
    for (int r = 0; r < 16; r++) begin
      @(posedge core_clk);
      eng_code <= rows[r];
      run(6'h01, 12'h00e, 1'b0, 1'b0);
      cmp("error code", rows[r], hq & 12'h0ff);
    end
    $display("test error codes done");
    run(6'h01, 12'h000, 1'b1, 1'b1);
    skipchk(6'h10, 1'b1, "parity error");
    skipchk(6'h10, 1'b0, "error cleared");
    cmp_bit("parity status", 1'b1, hq[dsk_port_pkg::ST_PARITY_BIT]);
    run(6'h01, 12'h00e, 1'b1, 1'b0);
    cmp("new parity code", dsk_port_pkg::ERR_PARITY, hq & 12'h0ff);
    $display("test parity done");
    @(posedge core_clk);
    crc <= 1'b1;
    eng_code <= 12'h000;
    run(6'h01, 12'h01a, 1'b0, 1'b0);
    cmp("status word", 12'h081, hq & 12'h083);
    cmp_bit("status wait", 1'b1, cyc >= 10);
    $display("test status done");
    stop_test();
  end
endmodule
`default_nettype wire
